// File: flash_pe_pkg.sv
// package: register map, control fields and constants of the flash program/erase control
package flash_pe_pkg;

    // ----------------------------------------------------------------
    // bus and address map
    // ----------------------------------------------------------------
    localparam int BUS_AW = 16;
    localparam logic [15:0] FLASH_CONTROL_ADDR = 16'hfe08;
    localparam logic [15:0] PROTECT_BYTE_ADDR = 16'hfff0;
    localparam logic [15:0] ARRAY_BASE_ADDR = 16'h7800;
    localparam int ARRAY_AW = 11;
    localparam int ARRAY_BYTES = 2048;

    // ----------------------------------------------------------------
    // reset and data values
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'h00;
    localparam logic [7:0] PROTECT_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // protected range start, as offset into the array, for protect bits 0..3
    localparam logic [10:0] PROTECT_START_0 = 11'h000;
    localparam logic [10:0] PROTECT_START_1 = 11'h080;
    localparam logic [10:0] PROTECT_START_2 = 11'h100;
    localparam logic [10:0] PROTECT_START_3 = 11'h200;

    // cared-address masks per erase block size
    localparam logic [10:0] MASK_FULL = 11'h000;
    localparam logic [10:0] MASK_HALF = 11'h400;
    localparam logic [10:0] MASK_EIGHT_ROWS = 11'h7c0;
    localparam logic [10:0] MASK_ROW = 11'h7f8;

    // extra bus cycles added to a margin read of the array
    localparam logic [3:0] MARGIN_EXTRA_CYCLES = 4'h8;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BLK_FULL = 2'b00,
        BLK_HALF = 2'b01,
        BLK_EIGHT_ROWS = 2'b10,
        BLK_ROW = 2'b11
    } block_size_e;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic reserved;
        logic pump_clock_halve;
        logic block_size_hi;
        logic block_size_lo;
        logic high_voltage_on;
        logic margin_select;
        logic erase_select;
        logic program_select;
    } flash_ctrl_s;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WAIT,
        BUS_DONE
    } bus_state_e;

endpackage

// File: pump_clock_div.sv
// charge pump clock enable, bus clock divided by one or two
module pump_clock_div (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic run_in,
    input wire logic halve_in,
    output logic pump_tick_out
);
    import flash_pe_pkg::*;

    logic phase_reg;

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------
    // free running phase; a tick every cycle or every second cycle
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase_reg <= 1'b0;
            pump_tick_out <= 1'b0;
        end else begin
            phase_reg <= ~phase_reg;
            pump_tick_out <= run_in & (~halve_in | phase_reg);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    pump_div_one_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (run_in && !halve_in) |=> pump_tick_out)
        else $error("pump tick missing in divide by one");

    pump_div_two_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (run_in && halve_in)[*3] |-> (pump_tick_out != $past(pump_tick_out)))
        else $error("pump tick not alternating in divide by two");

endmodule

// File: flash_program_erase_ctrl.sv
// flash program/erase control: register slave, array model, interlocks, protection
//
// Behaviour
// - erased bits read 0, programmed bits read 1; erased byte reads zero
// - rows of eight one-byte pages; program one byte, erase at least one row
// - pump clock is bus clock divided by one, or two when halve bit set
// - high voltage sets only with a select bit and the proper sequence done
// - margin select refuses to set and reads 0 while high voltage is on
// - program select and erase select are never both 1
// - block size 00 full, 01 half, 10 eight rows, 11 one row
// - during erase a flash write latches the cared address bits of the block
// - program select enables latching address and data of next flash write
// - array read in margin mode is stretched by eight more bus cycles
// - reading the protect byte latches it into the control logic
// - target in a protected block clears program and erase select
// - protect byte all zero blocks nothing
// - protect byte changes only with high voltage indication, which bypasses protection
// - steps keep order; unrelated bus accesses between them change nothing (here protect read and target write are accepted in either order)
// - each protect bit blocks from its start address to the top; bit 3 highest
//
// The implementer's own choice: the Avalon-MM interface to the registers.
module flash_program_erase_ctrl (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [flash_pe_pkg::BUS_AW-1:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [7:0] writedata_in,
    input wire logic high_voltage_indication_in,
    output logic [7:0] readdata_out,
    output logic waitrequest_out,
    output logic high_voltage_out,
    output logic margin_read_out,
    output logic pump_tick_out
);
    import flash_pe_pkg::*;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_array(input logic [BUS_AW-1:0] addr);
        return addr[BUS_AW-1:ARRAY_AW] == ARRAY_BASE_ADDR[BUS_AW-1:ARRAY_AW];
    endfunction

    function automatic logic [10:0] block_mask(input logic hi, input logic lo);
        logic [10:0] m;
        m = MASK_FULL;
        unique case (block_size_e'({hi, lo}))
            BLK_FULL: m = MASK_FULL;
            BLK_HALF: m = MASK_HALF;
            BLK_EIGHT_ROWS: m = MASK_EIGHT_ROWS;
            BLK_ROW: m = MASK_ROW;
        endcase
        return m;
    endfunction

    // lowest set protect bit picks the start; everything above it is locked
    function automatic logic range_blocked(input logic [3:0] prot, input logic [10:0] last_off,
                                           input logic on_protect_byte);
        logic [10:0] start;
        start = PROTECT_START_3;
        if (prot[2]) start = PROTECT_START_2;
        if (prot[1]) start = PROTECT_START_1;
        if (prot[0]) start = PROTECT_START_0;
        if (prot == 4'h0) return 1'b0;
        return on_protect_byte || (last_off >= start);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    flash_ctrl_s ctrl_reg;
    flash_ctrl_s ctrl_next;
    bus_state_e state_reg;
    logic [3:0] stretch_reg;
    logic [BUS_AW-1:0] addr_reg;
    logic read_reg;
    logic [7:0] wdata_reg;
    logic [7:0] cell_reg [ARRAY_BYTES];
    logic [7:0] protect_reg;
    logic [7:0] protect_latch_reg;
    logic protect_seen_reg;
    logic target_valid_reg;
    logic target_is_protect_reg;
    logic [10:0] target_off_reg;
    logic [7:0] target_data_reg;
    logic program_fire_reg;
    logic erase_fire_reg;
    logic access_now;
    logic do_write;
    logic do_read;
    logic violation;
    logic hv_allowed;
    logic [10:0] erase_mask;
    logic [10:0] last_off;
    logic [7:0] read_value;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    // an access completes in the cycle where the stretch count has run out
    assign access_now = (state_reg == BUS_WAIT) && (stretch_reg == 4'h0);
    assign do_write = access_now && !read_reg;
    assign do_read = access_now && read_reg;

    // read mux; array reads see the cells whether margin mode is on or not
    always_comb begin
        read_value = UNMAPPED_READ;
        if (addr_reg == FLASH_CONTROL_ADDR) begin
            read_value = ctrl_reg;
        end else if (addr_reg == PROTECT_BYTE_ADDR) begin
            read_value = protect_reg;
        end else if (is_array(addr_reg)) begin
            read_value = cell_reg[addr_reg[ARRAY_AW-1:0]];
        end
    end

    // one wait state per access, nine for a margin read of the array
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= BUS_IDLE;
            stretch_reg <= 4'h0;
            addr_reg <= '0;
            read_reg <= 1'b0;
            wdata_reg <= 8'h00;
            waitrequest_out <= 1'b1;
            readdata_out <= 8'h00;
        end else begin
            unique case (state_reg)
                BUS_IDLE: begin
                    if (read_in || write_in) begin
                        addr_reg <= address_in;
                        read_reg <= read_in;
                        wdata_reg <= writedata_in;
                        if (read_in && is_array(address_in) && ctrl_reg.margin_select) begin
                            stretch_reg <= MARGIN_EXTRA_CYCLES;
                        end else begin
                            stretch_reg <= 4'h0;
                        end
                        state_reg <= BUS_WAIT;
                    end
                end
                BUS_WAIT: begin
                    if (stretch_reg != 4'h0) begin
                        stretch_reg <= stretch_reg - 4'h1;
                    end else begin
                        waitrequest_out <= 1'b0;
                        if (read_reg) begin
                            readdata_out <= read_value;
                        end
                        state_reg <= BUS_DONE;
                    end
                end
                BUS_DONE: begin
                    waitrequest_out <= 1'b1;
                    state_reg <= BUS_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // protection check
    // ----------------------------------------------------------------
    assign erase_mask = block_mask(ctrl_reg.block_size_hi, ctrl_reg.block_size_lo);
    assign last_off = ctrl_reg.erase_select ? (target_off_reg | ~erase_mask) : target_off_reg;
    // the indication pin bypasses every protect bit
    assign violation = target_valid_reg && protect_seen_reg && !high_voltage_indication_in
        && range_blocked(protect_latch_reg[3:0], last_off, target_is_protect_reg);

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    assign hv_allowed = target_valid_reg && protect_seen_reg && !violation;

    // writes are filtered here so the interlocks hold whatever software sends
    always_comb begin
        flash_ctrl_s wr;
        wr = flash_ctrl_s'(wdata_reg);
        ctrl_next = ctrl_reg;
        if (violation) begin
            ctrl_next.program_select = 1'b0;
            ctrl_next.erase_select = 1'b0;
            ctrl_next.high_voltage_on = 1'b0;
        end
        if (do_write && addr_reg == FLASH_CONTROL_ADDR) begin
            ctrl_next.reserved = 1'b0;
            ctrl_next.pump_clock_halve = wr.pump_clock_halve;
            ctrl_next.block_size_hi = wr.block_size_hi;
            ctrl_next.block_size_lo = wr.block_size_lo;
            // both selects at once is refused: the old pair stays
            if (!(wr.program_select && wr.erase_select)) begin
                ctrl_next.program_select = wr.program_select;
                ctrl_next.erase_select = wr.erase_select;
            end
            if (!wr.high_voltage_on) begin
                ctrl_next.high_voltage_on = 1'b0;
            end else if (!ctrl_reg.high_voltage_on) begin
                ctrl_next.high_voltage_on = hv_allowed;
            end
            ctrl_next.margin_select = wr.margin_select && !ctrl_next.high_voltage_on
                && !ctrl_reg.high_voltage_on;
        end
        // high voltage never outlives its select
        if (!ctrl_next.program_select && !ctrl_next.erase_select) begin
            ctrl_next.high_voltage_on = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_reg <= flash_ctrl_s'(CTRL_RESET);
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // the array operation happens once, one cycle after the edge where high voltage rises
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            program_fire_reg <= 1'b0;
            erase_fire_reg <= 1'b0;
        end else begin
            program_fire_reg <= ctrl_next.high_voltage_on && !ctrl_reg.high_voltage_on
                && ctrl_next.program_select;
            erase_fire_reg <= ctrl_next.high_voltage_on && !ctrl_reg.high_voltage_on
                && ctrl_next.erase_select;
        end
    end

    assign high_voltage_out = ctrl_reg.high_voltage_on;
    assign margin_read_out = ctrl_reg.margin_select;

    // ----------------------------------------------------------------
    // sequence tracking
    // ----------------------------------------------------------------
    // flags survive unrelated accesses and drop only when both selects are clear
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            protect_seen_reg <= 1'b0;
            protect_latch_reg <= PROTECT_RESET;
        end else begin
            if (!ctrl_reg.program_select && !ctrl_reg.erase_select) begin
                protect_seen_reg <= 1'b0;
            end
            if (do_read && addr_reg == PROTECT_BYTE_ADDR) begin
                protect_latch_reg <= protect_reg;
                protect_seen_reg <= ctrl_reg.program_select || ctrl_reg.erase_select;
            end
        end
    end

    // target latch: program keeps address and data, erase only the cared bits
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            target_valid_reg <= 1'b0;
            target_is_protect_reg <= 1'b0;
            target_off_reg <= 11'h000;
            target_data_reg <= 8'h00;
        end else begin
            if (!ctrl_reg.program_select && !ctrl_reg.erase_select) begin
                target_valid_reg <= 1'b0;
            end
            if (do_write && (ctrl_reg.program_select || ctrl_reg.erase_select)
                && !ctrl_reg.high_voltage_on
                && (is_array(addr_reg) || addr_reg == PROTECT_BYTE_ADDR)) begin
                target_valid_reg <= 1'b1;
                target_is_protect_reg <= (addr_reg == PROTECT_BYTE_ADDR);
                target_data_reg <= wdata_reg;
                if (ctrl_reg.erase_select) begin
                    target_off_reg <= addr_reg[ARRAY_AW-1:0] & erase_mask;
                end else begin
                    target_off_reg <= addr_reg[ARRAY_AW-1:0];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // array and protect byte
    // ----------------------------------------------------------------
    // reset gives an erased array: this is a behavioural model, not retention
    for (genvar i = 0; i < ARRAY_BYTES; i++) begin : g_cell
        always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                cell_reg[i] <= ERASED_BYTE;
            end else if (erase_fire_reg && !target_is_protect_reg
                         && ((11'(i) & erase_mask) == target_off_reg)) begin
                cell_reg[i] <= ERASED_BYTE;
            end else if (program_fire_reg && !target_is_protect_reg
                         && target_off_reg == 11'(i)) begin
                cell_reg[i] <= cell_reg[i] | target_data_reg;
            end
        end
    end

    // protect byte follows the array, but only with the indication present
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            protect_reg <= PROTECT_RESET;
        end else if (high_voltage_indication_in) begin
            if (erase_fire_reg && (target_is_protect_reg || erase_mask == MASK_FULL)) begin
                protect_reg <= ERASED_BYTE;
            end else if (program_fire_reg && target_is_protect_reg) begin
                protect_reg <= protect_reg | target_data_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // pump clock
    // ----------------------------------------------------------------
    pump_clock_div u_pump (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .run_in(ctrl_reg.high_voltage_on),
        .halve_in(ctrl_reg.pump_clock_halve),
        .pump_tick_out(pump_tick_out)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence margin_read_taken;
        (state_reg == BUS_IDLE) && read_in && is_array(address_in) && ctrl_reg.margin_select;
    endsequence

    sequence nine_waits;
        waitrequest_out[*8] ##1 waitrequest_out ##1 !waitrequest_out;
    endsequence

    margin_stretch_a: assert property (margin_read_taken |=> nine_waits)
        else $error("margin read not stretched by eight cycles");

    plain_access_a: assert property (((state_reg == BUS_IDLE) && (read_in || write_in)
        && !(read_in && is_array(address_in) && ctrl_reg.margin_select))
        |=> waitrequest_out ##1 !waitrequest_out)
        else $error("plain access answer timing wrong");

    select_interlock_a: assert property (!(ctrl_reg.program_select && ctrl_reg.erase_select))
        else $error("program and erase selected together");

    margin_hv_a: assert property (ctrl_reg.high_voltage_on |-> !ctrl_reg.margin_select)
        else $error("margin select set with high voltage on");

    hv_sequence_a: assert property ($rose(ctrl_reg.high_voltage_on) |->
        $past(target_valid_reg && protect_seen_reg && !violation))
        else $error("high voltage set without proper sequence");

    protect_latch_a: assert property ((do_read && addr_reg == PROTECT_BYTE_ADDR) |=>
        (protect_latch_reg == $past(protect_reg)))
        else $error("protect byte not latched on read");

    blocked_clear_a: assert property (violation |=>
        (!ctrl_reg.program_select && !ctrl_reg.erase_select && !ctrl_reg.high_voltage_on))
        else $error("protected target left selected");

    open_protect_a: assert property ((protect_latch_reg[3:0] == 4'h0) |-> !violation)
        else $error("blocked with protect byte clear");

    program_sets_a: assert property (program_fire_reg && !target_is_protect_reg |=>
        ((cell_reg[target_off_reg] & target_data_reg) == target_data_reg))
        else $error("programmed bits do not read one");

    erase_clears_a: assert property (erase_fire_reg && !target_is_protect_reg |=>
        (cell_reg[target_off_reg | ~erase_mask] == ERASED_BYTE))
        else $error("erased block top byte not zero");

endmodule

// File: flash_program_erase_ctrl_tb_top.sv
// self-checking bench for the flash program/erase control block
module flash_program_erase_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_pe_pkg::*;
    // ----------------------------------------------------------------
    // clock, reset, bus signals
    // ----------------------------------------------------------------
    logic sys_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [15:0] address_in = 16'h0000;
    logic read_in = 1'b0;
    logic write_in = 1'b0;
    logic [7:0] writedata_in = 8'h00;
    logic high_voltage_indication_in = 1'b0;
    logic [7:0] readdata_out;
    logic waitrequest_out;
    logic high_voltage_out;
    logic margin_read_out;
    logic pump_tick_out;
    int err_count = 0;
    int compares = 0;
    int base_n;
    int n;
    logic [7:0] rd;
`define check(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
    // 125 MHz keeps the bus clock far above the lowest rate for array work
    always #4 sys_clk_in = ~sys_clk_in;
    flash_program_erase_ctrl dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .address_in(address_in), .read_in(read_in), .write_in(write_in),
        .writedata_in(writedata_in), .high_voltage_indication_in(high_voltage_indication_in),
        .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
        .high_voltage_out(high_voltage_out), .margin_read_out(margin_read_out),
        .pump_tick_out(pump_tick_out));
    // ----------------------------------------------------------------
    // bus tasks: request held until waitrequest is sampled low
    // ----------------------------------------------------------------
    // no cycle limit here: only the watchdog may end a wait for the answer
    task automatic bw(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        address_in <= a;
        writedata_in <= d;
        write_in <= 1'b1;
        do begin
            @(posedge sys_clk_in);
        end while (waitrequest_out !== 1'b0);
        write_in <= 1'b0;
    endtask
    task automatic br(input logic [15:0] a);
        n = 0;
        @(posedge sys_clk_in);
        address_in <= a;
        read_in <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (waitrequest_out !== 1'b0);
        rd = readdata_out;
        read_in <= 1'b0;
    endtask
    // one program or erase pass; ticks is the pump count expected over four cycles
    task automatic op(input logic [7:0] ctl, input logic [15:0] a, input logic [7:0] d,
                      input int ticks);
        int t;
        t = 0;
        bw(FLASH_CONTROL_ADDR, ctl); // select first, then protect read, then target
        br(PROTECT_BYTE_ADDR); // protect read latched before high voltage
        bw(16'h0040, 8'hff); // unrelated access between steps is harmless
        bw(a, d);
        bw(FLASH_CONTROL_ADDR, ctl | 8'h08);
        repeat (2) @(posedge sys_clk_in);
        repeat (4) begin
            @(posedge sys_clk_in);
            t += (pump_tick_out === 1'b1);
        end
        `check(t, ticks)
        `check(high_voltage_out, ticks != 0)
        bw(FLASH_CONTROL_ADDR, ctl & 8'hf7); // drop high voltage, then the select
        bw(FLASH_CONTROL_ADDR, 8'h00);
    endtask
    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        br(FLASH_CONTROL_ADDR);
        `check(rd, CTRL_RESET)
        br(16'h7810);
        `check(rd, ERASED_BYTE)
        br(PROTECT_BYTE_ADDR);
        `check(rd, 8'h00)
        br(16'h1234);
        `check(rd, UNMAPPED_READ)
        base_n = n;
    endtask
    task automatic t_interlock;
        bw(FLASH_CONTROL_ADDR, 8'h03);
        br(FLASH_CONTROL_ADDR);
        `check(rd[1:0], 2'b00)
        bw(FLASH_CONTROL_ADDR, 8'h08);
        br(FLASH_CONTROL_ADDR);
        `check(rd[3], 1'b0)
    endtask
    task automatic t_program;
        op(8'h01, 16'h7810, 8'ha5, 4);
        op(8'h01, 16'h7818, 8'h3c, 4);
        bw(FLASH_CONTROL_ADDR, 8'h01);
        br(PROTECT_BYTE_ADDR);
        bw(16'h7820, 8'h01);
        bw(FLASH_CONTROL_ADDR, 8'h0d);
        br(FLASH_CONTROL_ADDR);
        `check(rd[2], 1'b0)
        `check(margin_read_out, 1'b0)
        bw(FLASH_CONTROL_ADDR, 8'h01);
        bw(FLASH_CONTROL_ADDR, 8'h05); // verify pass: margin on, program select kept
        bw(FLASH_CONTROL_ADDR, 8'h04);
        `check(margin_read_out, 1'b1)
        br(16'h7810);
        `check(rd, 8'ha5)
        `check(n - base_n, int'(MARGIN_EXTRA_CYCLES))
        br(16'h7820);
        `check(rd, 8'h01)
        bw(FLASH_CONTROL_ADDR, 8'h00);
    endtask
    // the row has seen one program, well under eight, when it is erased
    task automatic t_erase_row;
        op(8'h72, 16'h7813, 8'h00, 2); // halved pump, single row block
        br(16'h7810);
        `check(rd, 8'h00)
        br(16'h7818);
        `check(rd, 8'h3c)
    endtask
    task automatic t_protect;
        high_voltage_indication_in <= 1'b1;
        op(8'h01, PROTECT_BYTE_ADDR, 8'h02, 4);
        op(8'h01, 16'h7900, 8'h44, 4);
        high_voltage_indication_in <= 1'b0;
        br(PROTECT_BYTE_ADDR);
        `check(rd, 8'h02)
        op(8'h01, 16'h7800, 8'h11, 4);
        op(8'h01, 16'h7880, 8'h22, 0);
        op(8'h22, 16'h7900, 8'h00, 0);
        br(16'h7900);
        `check(rd, 8'h44)
        br(16'h7800);
        `check(rd, 8'h11)
    endtask
    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        t_reset();
        t_interlock();
        t_program();
        t_erase_row();
        t_protect();
        stop_test();
    end
    initial begin
        #400000;
        err_count++;
        $display("ERROR %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
